// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ulsr_pkg::*;
;
  // Short counts keep the run brief
  localparam int BITS  = 4;
  localparam int DEPTH = 4;
  localparam logic [31:0] stAvail  = 32'h1 << LS_AVAIL_BIT;
  localparam logic [31:0] stOver   = 32'h1 << LS_OVERRUN_BIT;
  localparam logic [31:0] stParity = 32'h1 << LS_PARITY_BIT;
  localparam logic [31:0] stBreak  = 32'h1 << LS_BREAK_BIT;
  localparam logic [31:0] ctlEven  = (32'h1 << LC_PEN_BIT) | (32'h1 << LC_EVEN_BIT);
  // Clock, reset and bus
  logic        clk         = 1'b0;
  logic        reset       = 1'b1;
  logic [3:0]  address     = 4'h0;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rxSerialIn;
  logic [31:0] rdv;
  int          fails       = 0;
  int          nCompared   = 0;

  always #2.5 clk = ~clk;

  ulsr_line_status #(.BIT_CYCLES(BITS), .FIFO_DEPTH(DEPTH)) dut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rxSerialIn(rxSerialIn));
  ulsr_serial_tx #(.BIT_CYCLES(BITS)) tx (.clk(clk), .rxSerialIn(rxSerialIn));

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= ~we;
    write <= we;
    writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("[FAIL] %0t bus request not answered", $time);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    logic [31:0] junk;
    xfer(1'b1, a, wd, junk);
  endtask

  task automatic chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0, rdv);
    nCompared++;
    if (rdv !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, rdv, exp);
    end
  endtask

  // Character with even parity, optionally corrupted
  task automatic rx(input logic [7:0] d, input logic withPar, input logic bad);
    tx.send(d, withPar, (^d) ^ bad, 1'b1);
    repeat (4) @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    chk(LINE_STATUS_OFS, 32'h0, "status after reset");
    chk(LINE_CTRL_OFS, 32'h0, "line control after reset");
    chk(FIFO_CTRL_OFS, 32'h0, "fifo control after reset");
    wr(4'h2, 32'hFF);
    chk(4'h2, 32'h0, "unmapped address");
    $display("test reset finished");
    // Buffer mode: second character lands before the first is read
    wr(LINE_CTRL_OFS, ctlEven);
    chk(LINE_CTRL_OFS, ctlEven, "line control readback");
    rx(8'h3C, 1'b1, 1'b0);
    chk(LINE_STATUS_OFS, stAvail, "one character waiting");
    rx(8'hC3, 1'b1, 1'b0);
    chk(LINE_STATUS_OFS, stAvail | stOver, "overrun shown");
    chk(RX_DATA_OFS, 32'hC3, "newer character kept");
    chk(LINE_STATUS_OFS, 32'h0, "overrun and avail cleared");
    $display("test overrun finished");
    rx(8'h5A, 1'b1, 1'b1);
    chk(LINE_STATUS_OFS, stAvail | stParity, "parity error shown");
    chk(LINE_STATUS_OFS, stAvail, "parity error read-cleared");
    chk(RX_DATA_OFS, 32'h5A, "bad parity data");
    // Odd parity: the even-parity helper's corrupt bit gives a correct odd frame
    wr(LINE_CTRL_OFS, 32'h1 << LC_PEN_BIT);
    rx(8'h96, 1'b1, 1'b1);
    chk(LINE_STATUS_OFS, stAvail, "odd parity accepted");
    chk(RX_DATA_OFS, 32'h96, "odd parity data");
    rx(8'h96, 1'b1, 1'b0);
    chk(LINE_STATUS_OFS, stAvail | stParity, "odd parity error");
    chk(RX_DATA_OFS, 32'h96, "odd parity bad data");
    wr(LINE_CTRL_OFS, 32'h0);
    rx(8'h81, 1'b0, 1'b0);
    chk(LINE_STATUS_OFS, stAvail, "no parity check when off");
    chk(RX_DATA_OFS, 32'h81, "data without parity");
    $display("test parity finished");
    // All-low frame, line low through the stop bit, then high for one idle bit
    tx.send(8'h00, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    chk(LINE_STATUS_OFS, stAvail | stParity | stBreak, "break flags");
    chk(RX_DATA_OFS, 32'h0, "break data");
    chk(LINE_STATUS_OFS, 32'h0, "break cleared");
    $display("test break finished");
    // FIFO mode: error follows its character to the head
    wr(LINE_CTRL_OFS, ctlEven);
    wr(FIFO_CTRL_OFS, 32'h1 << FC_ENABLE_BIT);
    rx(8'h33, 1'b1, 1'b0);
    rx(8'h5A, 1'b1, 1'b1);
    chk(LINE_STATUS_OFS, stAvail, "good head hides later error");
    chk(RX_DATA_OFS, 32'h33, "fifo head first");
    chk(LINE_STATUS_OFS, stAvail | stParity, "error at head");
    chk(RX_DATA_OFS, 32'h5A, "fifo second");
    chk(LINE_STATUS_OFS, 32'h0, "fifo empty");
    // One character more than the FIFO holds, no reads meanwhile
    for (int i = 0; i <= DEPTH; i++) rx(8'h10 + 8'(i), 1'b1, 1'b0);
    chk(LINE_STATUS_OFS, stAvail | stOver, "fifo overrun");
    for (int i = 0; i < DEPTH; i++) chk(RX_DATA_OFS, 32'h10 + i, "fifo kept");
    chk(LINE_STATUS_OFS, 32'h0, "drained, last char lost");
    // Leaving FIFO mode throws away what is waiting
    rx(8'h77, 1'b1, 1'b0);
    chk(LINE_STATUS_OFS, stAvail, "char waiting before mode change");
    wr(FIFO_CTRL_OFS, 32'h0);
    chk(LINE_STATUS_OFS, 32'h0, "mode change flushes");
    $display("test fifo finished");
    give_verdict();
  end
endmodule
`default_nettype wire

// File: sim/ulsr_serial_tx.sv
`timescale 1ns/1ps
`default_nettype none
module ulsr_serial_tx #(
  parameter int BIT_CYCLES = 4
) (
  // Clock
  input  wire logic clk,
  // Serial line, idles high
  output logic      rxSerialIn
);
  initial rxSerialIn = 1'b1;

  // One bit on the line, changed just after a clock edge
  task automatic put_bit(input logic b);
    rxSerialIn <= b;
    repeat (BIT_CYCLES) @(posedge clk);
  endtask

  // Start, 8 data LSB first, optional parity, stop; a low stop with all-low data and parity gives a break frame
  task automatic send(input logic [7:0] d, input logic withPar, input logic par,
                      input logic stopV);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    if (withPar) put_bit(par);
    put_bit(stopV);
    // Extra idle bit so a break frame is always followed by a high line
    put_bit(1'b1);
  endtask
endmodule
`default_nettype wire

// File: verilog/ulsr_line_status.sv
// Notes on behaviour
// - FIFO mode: parity error shown at head
// - Break also raises the parity error flag
// - Parity flag one on error; status read clears
// - Non-FIFO: unread character overwritten, overrun set
// - FIFO mode: character into full FIFO overruns
// - FIFO overrun keeps FIFO, drops new character
// - Overrun flag one after overrun; read clears
// - Data available bit 0 is one while characters wait
// - Data available drops when a read or flush leaves it empty
// - Parity checked only with parity enable on
// - Break flag after all-low character time
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ulsr_line_status
  import ulsr_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Serial line
  input  wire logic        rxSerialIn
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2 - 1);
  localparam logic [15:0] FULL_BIT = 16'(BIT_CYCLES - 1);

  logic                 rxSync1;
  logic                 rxLine;
  logic                 rxPrev;
  ulsr_rx_state_t       rxState;
  logic [15:0]          bitTimer;
  logic [2:0]           bitIdx;
  logic [CHAR_BITS-1:0] shiftReg;
  logic                 parBit;
  logic                 charDone;
  logic [ENTRY_W-1:0]   charWord;
  logic [7:0]           lineCtrl;
  logic                 fifoMode;
  logic                 parityFlag;
  logic                 overrunFlag;
  logic                 breakFlag;
  logic                 headNew;
  logic [ENTRY_W-1:0]   headData;
  logic [CW-1:0]        count;
  logic                 accept;
  logic                 lsrRead;
  logic                 rbrRead;
  logic                 popReq;
  logic                 fifoFull;
  logic                 push;
  logic                 pop;
  logic                 overrunEvt;
  logic                 flush;
  logic                 headLoad;
  logic                 headBreak;
  logic                 headParity;

  function automatic logic isAddr(input logic [3:0] a, input logic [3:0] ofs);
    isAddr = (a == ofs);
  endfunction

  // Bus: one wait cycle, effects land on the accepting edge
  assign accept   = (read || write) && !waitrequest;
  assign lsrRead  = accept && read && isAddr(address, LINE_STATUS_OFS);
  assign rbrRead  = accept && read && isAddr(address, RX_DATA_OFS);
  assign popReq   = rbrRead && (count != '0);
  assign fifoFull = (count == CW'(FIFO_DEPTH));
  assign flush    = accept && write && isAddr(address, FIFO_CTRL_OFS)
                    && (writedata[FC_ENABLE_BIT] != fifoMode);
  // A new character fills a free slot or replaces the single held one; into a full FIFO with no read it is dropped
  assign push       = charDone && (fifoMode ? (!fifoFull || popReq) : 1'b1);
  assign pop        = popReq || (!fifoMode && charDone && (count != '0));
  assign overrunEvt = charDone && !popReq
                      && (fifoMode ? fifoFull : (count != '0));
  assign headLoad   = (push && ((count == '0) || pop)) || (pop && (count > CW'(1)));
  assign headBreak  = headNew && (count != '0) && headData[ENTRY_W-1];
  assign headParity = headNew && (count != '0) && headData[ENTRY_W-2];

  ulsr_rx_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) rxFifo (
    .clk      (clk),
    .reset    (reset),
    .flush    (flush),
    .push     (push),
    .pushData (charWord),
    .pop      (pop),
    .headData (headData),
    .count    (count)
  );

  // The first flop only feeds the second; rxPrev gives edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxSync1 <= 1'h1;
      rxLine  <= 1'h1;
      rxPrev  <= 1'h1;
    end else begin
      rxSync1 <= rxSerialIn;
      rxLine  <= rxSync1;
      rxPrev  <= rxLine;
    end
  end

  // Receiver; a new start needs a falling edge, so a held break yields one character
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxState  <= RX_IDLE;
      bitTimer <= 16'h0000;
      bitIdx   <= 3'h0;
      shiftReg <= '0;
      parBit   <= 1'h0;
      charDone <= 1'h0;
      charWord <= '0;
    end else begin
      charDone <= 1'h0;
      if (rxState != RX_IDLE) begin
        bitTimer <= bitTimer - 16'h0001;
      end
      case (rxState)
        RX_IDLE: begin
          parBit <= 1'h0;
          if (rxPrev && !rxLine) begin
            rxState  <= RX_START;
            bitTimer <= HALF_BIT;
          end
        end
        RX_START: begin
          if (bitTimer == 16'h0000) begin
            rxState  <= rxLine ? RX_IDLE : RX_DATA;
            bitTimer <= FULL_BIT;
            bitIdx   <= 3'h0;
          end
        end
        RX_DATA: begin
          if (bitTimer == 16'h0000) begin
            shiftReg <= {rxLine, shiftReg[CHAR_BITS-1:1]};
            bitIdx   <= bitIdx + 3'h1;
            bitTimer <= FULL_BIT;
            if (bitIdx == 3'h7) begin
              rxState <= lineCtrl[LC_PEN_BIT] ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (bitTimer == 16'h0000) begin
            parBit   <= rxLine;
            bitTimer <= FULL_BIT;
            rxState  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bitTimer == 16'h0000) begin
            rxState  <= RX_IDLE;
            charDone <= 1'h1;
            charWord[CHAR_BITS-1:0] <= shiftReg;
            charWord[ENTRY_W-1] <= !rxLine && (shiftReg == '0) && !parBit;
            charWord[ENTRY_W-2] <= lineCtrl[LC_PEN_BIT]
                                   && ((^{shiftReg, parBit}) == lineCtrl[LC_EVEN_BIT]);
          end
        end
        default: begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lineCtrl <= LINE_CTRL_RESET;
      fifoMode <= FIFO_EN_RESET;
    end else if (accept && write) begin
      if (isAddr(address, LINE_CTRL_OFS)) begin
        lineCtrl <= writedata[7:0];
      end else if (isAddr(address, FIFO_CTRL_OFS)) begin
        fifoMode <= writedata[FC_ENABLE_BIT];
      end
    end
  end

  // Head flags are taken one cycle after the head changes, when its word is visible
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      headNew <= 1'h0;
    end else begin
      headNew <= headLoad && !flush;
    end
  end

  // Only bits already returned are cleared, so an event during the read survives
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      parityFlag  <= 1'h0;
      overrunFlag <= 1'h0;
      breakFlag   <= 1'h0;
    end else begin
      parityFlag  <= headParity || headBreak
                     || (parityFlag && !(lsrRead && readdata[LS_PARITY_BIT]));
      overrunFlag <= overrunEvt
                     || (overrunFlag && !(lsrRead && readdata[LS_OVERRUN_BIT]));
      breakFlag   <= headBreak
                     || (breakFlag && !(lsrRead && readdata[LS_BREAK_BIT]));
    end
  end

  // Read data is captured in the wait cycle, before any read side effect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'h1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) begin
        readdata <= 32'h0000_0000;
        if (isAddr(address, RX_DATA_OFS)) begin
          readdata[CHAR_BITS-1:0] <= (count != '0) ? headData[CHAR_BITS-1:0] : '0;
        end else if (isAddr(address, LINE_CTRL_OFS)) begin
          readdata[7:0] <= lineCtrl;
        end else if (isAddr(address, FIFO_CTRL_OFS)) begin
          readdata[FC_ENABLE_BIT] <= fifoMode;
        end else if (isAddr(address, LINE_STATUS_OFS)) begin
          readdata[LS_AVAIL_BIT]   <= (count != '0);
          readdata[LS_OVERRUN_BIT] <= overrunFlag;
          readdata[LS_PARITY_BIT]  <= parityFlag;
          readdata[LS_BREAK_BIT]   <= breakFlag;
        end
      end
    end
  end

  sequence lsrAsk;
    read && waitrequest && isAddr(address, LINE_STATUS_OFS);
  endsequence
  sequence lsrDone;
    read && !waitrequest && isAddr(address, LINE_STATUS_OFS);
  endsequence

  chk_parity_head: assert property (@(posedge clk) disable iff (reset)
    headParity |=> parityFlag) else $error("parity flag missed head error");
  chk_break_parity: assert property (@(posedge clk) disable iff (reset)
    breakFlag |-> parityFlag) else $error("break without parity flag");
  chk_parity_clear: assert property (@(posedge clk) disable iff (reset)
    lsrDone ##0 (readdata[LS_PARITY_BIT] && !headParity && !headBreak) |=> !parityFlag)
    else $error("parity flag not cleared by status read");
  chk_nofifo_overrun: assert property (@(posedge clk) disable iff (reset)
    (!fifoMode && charDone && count != '0 && !rbrRead) |=> (overrunFlag && count == CW'(1)))
    else $error("non-FIFO overrun mishandled");
  chk_fifo_overrun: assert property (@(posedge clk) disable iff (reset)
    (fifoMode && charDone && fifoFull && !rbrRead && !flush) |=> overrunFlag)
    else $error("FIFO overrun not flagged");
  chk_fifo_kept: assert property (@(posedge clk) disable iff (reset)
    (fifoMode && overrunEvt && !flush) |=> $stable(count) && $stable(headData))
    else $error("FIFO changed on overrun");
  chk_overrun_clear: assert property (@(posedge clk) disable iff (reset)
    lsrDone ##0 (readdata[LS_OVERRUN_BIT] && !overrunEvt) |=> !overrunFlag)
    else $error("overrun flag not cleared by status read");
  chk_avail_shown: assert property (@(posedge clk) disable iff (reset)
    lsrAsk ##0 (count != '0) |=> readdata[LS_AVAIL_BIT])
    else $error("data available bit wrong");
  chk_avail_drop: assert property (@(posedge clk) disable iff (reset)
    (!fifoMode && rbrRead && !charDone && count == CW'(1)) |=> count == '0)
    else $error("data not dropped after buffer read");
  chk_parity_off: assert property (@(posedge clk) disable iff (reset)
    (charDone && !lineCtrl[LC_PEN_BIT] && !$past(lineCtrl[LC_PEN_BIT], 2)) |-> !charWord[ENTRY_W-2])
    else $error("parity checked while disabled");
  chk_break_head: assert property (@(posedge clk) disable iff (reset)
    headBreak |=> breakFlag) else $error("break flag not raised");
  chk_read_before_clear: assert property (@(posedge clk) disable iff (reset)
    lsrAsk ##0 overrunFlag |=> overrunFlag) else $error("flag cleared before answer");
endmodule
`default_nettype wire

// File: verilog/ulsr_pkg.sv
`default_nettype none
package ulsr_pkg;
  // Avalon byte offsets, one 32-bit word each
  localparam logic [3:0] RX_DATA_OFS     = 4'h0;
  localparam logic [3:0] LINE_CTRL_OFS   = 4'h4;
  localparam logic [3:0] FIFO_CTRL_OFS   = 4'h8;
  localparam logic [3:0] LINE_STATUS_OFS = 4'hC;
  // Line status fields
  localparam int LS_AVAIL_BIT   = 0;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_PARITY_BIT  = 2;
  localparam int LS_BREAK_BIT   = 4;
  // Line control and FIFO control fields
  localparam int LC_PEN_BIT    = 3;
  localparam int LC_EVEN_BIT   = 4;
  localparam int FC_ENABLE_BIT = 0;
  // Reset values
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic       FIFO_EN_RESET   = 1'h0;
  // Sizes and cycle counts
  localparam int CHAR_BITS          = 8;
  localparam int ENTRY_W            = CHAR_BITS + 2;
  localparam int BIT_CYCLES_DEFAULT = 16;
  localparam int FIFO_DEPTH_DEFAULT = 16;
  typedef enum logic [2:0] {
    RX_IDLE   = 3'h0,
    RX_START  = 3'h1,
    RX_DATA   = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP   = 3'h6
  } ulsr_rx_state_t;
endpackage
`default_nettype wire

// File: verilog/ulsr_rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ulsr_rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Control
  input  wire logic                       flush,
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           pushData,
  input  wire logic                       pop,
  // State
  output logic      [WIDTH-1:0]           headData,
  output logic      [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    rdPtr;
  logic [PW-1:0]    wrPtr;
  logic             doPop;
  logic             doPush;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign doPop    = pop && (count != '0);
  assign doPush   = push && ((count != ($clog2(DEPTH+1))'(DEPTH)) || doPop);
  assign headData = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= pushData;
    end
  end

  // Flush wins so a mode change never leaves stale characters
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end else if (flush) begin
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end else begin
      if (doPop) begin
        rdPtr <= bump(rdPtr);
      end
      if (doPush) begin
        wrPtr <= bump(wrPtr);
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
